/* File: shared/cpq_pkg.sv */
// package with constants and types for the pc and address quirk block
package cpq_pkg;
   localparam int CPQ_AW = 20;
   localparam int CPQ_DW = 16;
   // pc base correction of this core and of the predecessor core
   localparam logic [CPQ_AW-1:0] CPQ_PC_CORR = 20'h00002;
   localparam logic [CPQ_AW-1:0] CPQ_PC_CORR_OLD = 20'h00004;
   // fetch address step after each instruction word
   localparam logic [CPQ_AW-1:0] CPQ_FETCH_STEP = 20'h00002;
   // boundary of the lower 64k window
   localparam int CPQ_LOW_W = 16;
   localparam logic [CPQ_AW-1:0] CPQ_PC_RESET = 20'h00000;
   // number of memory sections checked for vacant access
   localparam int CPQ_NSEC = 4;
   // pc modification kinds
   typedef enum logic [1:0]
   {
      CPQ_PM_NONE = 2'b00,
      CPQ_PM_ARITH = 2'b01,
      CPQ_PM_MOVE = 2'b10
   } cpq_pcmod_t;
   // source addressing modes
   typedef enum logic [2:0]
   {
      CPQ_AM_REG = 3'b000,
      CPQ_AM_IDX = 3'b001,
      CPQ_AM_SYM = 3'b010,
      CPQ_AM_ABS = 3'b011,
      CPQ_AM_IND = 3'b100,
      CPQ_AM_INC = 3'b101,
      CPQ_AM_IMM = 3'b110
   } cpq_am_t;
   // interrupt stacking states
   typedef enum logic [1:0]
   {
      CPQ_ST_IDLE = 2'b00,
      CPQ_ST_PUSH1 = 2'b01,
      CPQ_ST_PUSH2 = 2'b10
   } cpq_stack_t;
endpackage : cpq_pkg

/* File: verilog/cpq_section_map.sv */
// section map: flags fetch addresses that fall outside every valid section
`timescale 1ns/1ps
`default_nettype none
module cpq_section_map
   import cpq_pkg::*;
#(
   parameter int NSEC = CPQ_NSEC
)
(
   input wire logic mclk_in,
   input wire logic rst_n_in,
   input wire logic [NSEC*CPQ_AW-1:0] sec_lo_in,
   input wire logic [NSEC*CPQ_AW-1:0] sec_hi_in,
   input wire logic [CPQ_AW-1:0] addr_in,
   input wire logic check_in,
   output logic vacant_out
);
   logic [NSEC-1:0] hit;

   // ---------------------------------------------------------------
   // per-section range compare
   // ---------------------------------------------------------------
   genvar g;
   generate
      for (g = 0; g < NSEC; g++)
      begin : g_sec
         assign hit[g] = (addr_in >= sec_lo_in[g*CPQ_AW +: CPQ_AW]) &&
                         (addr_in <= sec_hi_in[g*CPQ_AW +: CPQ_AW]);
      end
   endgenerate

   // registered so the vacant answer lines up with the next cycle
   always_ff @(posedge mclk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
         vacant_out <= 1'b0;
      else
         vacant_out <= check_in && (hit == '0);
   end
endmodule : cpq_section_map
`default_nettype wire

/* File: verilog/cpq_core.sv */
// pc handling quirks of the cpu core: pc offset, 64k wrap, stacking, vacant flag
`timescale 1ns/1ps
`default_nettype none
module cpq_core
   import cpq_pkg::*;
#(
   parameter int NSEC = CPQ_NSEC
)
(
   input wire logic mclk_in,
   input wire logic rst_n_in,
   // memory section map, packed low section first
   input wire logic [NSEC*CPQ_AW-1:0] sec_lo_in,
   input wire logic [NSEC*CPQ_AW-1:0] sec_hi_in,
   // decoded instruction, one-cycle strobe
   input wire logic instr_valid_in,
   input wire logic [CPQ_AW-1:0] instr_addr_in,
   input wire cpq_pcmod_t pcmod_in,
   input wire cpq_am_t src_mode_in,
   input wire logic [CPQ_AW-1:0] operand_in,
   input wire logic [CPQ_AW-1:0] move_src_in,
   input wire logic far_indexed_in,
   input wire logic [CPQ_AW-1:0] base_reg_in,
   input wire logic [CPQ_DW-1:0] index_in,
   input wire logic sets_lpm_in,
   input wire logic is_call_in,
   // interrupt side
   input wire logic irq_req_in,
   input wire logic irq_take_in,
   input wire logic [CPQ_DW-1:0] sr_in,
   output logic [CPQ_AW-1:0] pc_out,
   output logic [CPQ_AW-1:0] ea_out,
   output logic ea_valid_out,
   output logic push_valid_out,
   output logic [CPQ_AW-1:0] push_data_out,
   output logic push_is_sr_out,
   output logic vacant_access_flag_out,
   output logic [CPQ_AW-1:0] fetch_address_bus_out
);
   logic lpm_prev;
   logic defect_armed;
   logic twice_pc;
   logic irq_fetched;
   logic map_check;
   logic map_vacant;
   logic [CPQ_AW-1:0] check_addr;
   logic [CPQ_AW-1:0] saved_sr;
   cpq_stack_t st;
   cpq_stack_t next_st;
   logic [CPQ_AW-1:0] ea_full;
   logic pc_arith;

   // pc-modifying decode used by the vacant fetch check
   function automatic logic is_pcmod(input cpq_pcmod_t m);
      is_pcmod = (m != CPQ_PM_NONE);
   endfunction : is_pcmod

   // ---------------------------------------------------------------
   // program counter update
   // ---------------------------------------------------------------
   assign pc_arith = (pcmod_in == CPQ_PM_ARITH) &&
                     ((src_mode_in == CPQ_AM_IMM) || (src_mode_in == CPQ_AM_IND));

   // with an immediate or indirect source the arithmetic base sits 2h ahead and corrects by 2h; other source modes correct by 4h
   always_ff @(posedge mclk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
         pc_out <= CPQ_PC_RESET;
      else if (instr_valid_in)
      begin
         if (pc_arith)
            pc_out <= instr_addr_in + CPQ_PC_CORR + operand_in;
         else if (pcmod_in == CPQ_PM_ARITH)
            pc_out <= instr_addr_in + CPQ_PC_CORR_OLD + operand_in;
         else if (pcmod_in == CPQ_PM_MOVE)
            pc_out <= move_src_in;
         else
            pc_out <= instr_addr_in + CPQ_FETCH_STEP;
      end
   end

   // ---------------------------------------------------------------
   // far indexed effective address
   // ---------------------------------------------------------------
   assign ea_full = base_reg_in + {{(CPQ_AW-CPQ_DW){index_in[CPQ_DW-1]}}, index_in};

   // a base below 64k never carries upward: the defect keeps the sum in 64k
   always_ff @(posedge mclk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         ea_out <= '0;
         ea_valid_out <= 1'b0;
      end
      else
      begin
         ea_valid_out <= instr_valid_in && far_indexed_in;
         if (instr_valid_in && far_indexed_in)
         begin
            if (base_reg_in[CPQ_AW-1:CPQ_LOW_W] == '0)
               ea_out <= {{(CPQ_AW-CPQ_LOW_W){1'b0}}, ea_full[CPQ_LOW_W-1:0]};
            else
               ea_out <= ea_full;
         end
      end
   end

   // ---------------------------------------------------------------
   // low-power then call hazard tracking
   // ---------------------------------------------------------------
   // only the instruction right after the low-power write counts; a no-op clears it
   always_ff @(posedge mclk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
         lpm_prev <= 1'b0;
      else if (instr_valid_in)
         lpm_prev <= sets_lpm_in && (src_mode_in != CPQ_AM_IMM);
   end

   // the hazard stays armed until the next interrupt entry consumes it
   always_ff @(posedge mclk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
         defect_armed <= 1'b0;
      else if (instr_valid_in && lpm_prev && is_call_in)
         defect_armed <= 1'b1;
      else if (st == CPQ_ST_IDLE && irq_take_in)
         defect_armed <= 1'b0;
   end

   // armed state frozen at entry, so a call landing on the entry edge waits for the next one
   always_ff @(posedge mclk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
         twice_pc <= 1'b0;
      else if (st == CPQ_ST_IDLE && irq_take_in)
         twice_pc <= defect_armed;
   end

   // ---------------------------------------------------------------
   // interrupt stacking sequence
   // ---------------------------------------------------------------
   always_comb
   begin
      next_st = st;
      case (st)
         CPQ_ST_IDLE: if (irq_take_in) next_st = CPQ_ST_PUSH1;
         CPQ_ST_PUSH1: next_st = CPQ_ST_PUSH2;
         CPQ_ST_PUSH2: next_st = CPQ_ST_IDLE;
         default: next_st = CPQ_ST_IDLE;
      endcase
   end

   always_ff @(posedge mclk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
         st <= CPQ_ST_IDLE;
      else
         st <= next_st;
   end

   // status is captured at entry so the second push shows the entry value
   always_ff @(posedge mclk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
         saved_sr <= '0;
      else if (st == CPQ_ST_IDLE && irq_take_in)
         saved_sr <= {{(CPQ_AW-CPQ_DW){1'b0}}, sr_in};
   end

   // pc first, then status; when armed the pc goes out twice and status is lost
   always_ff @(posedge mclk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         push_valid_out <= 1'b0;
         push_data_out <= '0;
         push_is_sr_out <= 1'b0;
      end
      else
      begin
         push_valid_out <= (next_st == CPQ_ST_PUSH1) || (next_st == CPQ_ST_PUSH2);
         push_is_sr_out <= 1'b0;
         push_data_out <= '0;
         if (next_st == CPQ_ST_PUSH1)
            push_data_out <= pc_out;
         else if (next_st == CPQ_ST_PUSH2)
         begin
            push_data_out <= twice_pc ? pc_out : saved_sr;
            push_is_sr_out <= !twice_pc;
         end
      end
   end

   // ---------------------------------------------------------------
   // vacant access flag
   // ---------------------------------------------------------------
   // an interrupt seen but dropped before it is taken counts as a lost fetch
   always_ff @(posedge mclk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
         irq_fetched <= 1'b0;
      else
         irq_fetched <= irq_req_in && !irq_take_in && (st == CPQ_ST_IDLE);
   end

   // the fetch unit runs ahead by one word after a pc-modifying instruction
   assign check_addr = instr_addr_in + CPQ_FETCH_STEP;
   assign map_check = instr_valid_in && is_pcmod(pcmod_in);

   cpq_section_map #(
      .NSEC(NSEC)
   ) u_map (
      .mclk_in(mclk_in),
      .rst_n_in(rst_n_in),
      .sec_lo_in(sec_lo_in),
      .sec_hi_in(sec_hi_in),
      .addr_in(check_addr),
      .check_in(map_check),
      .vacant_out(map_vacant)
   );

   // one-cycle pulse per spurious access; leaving four bytes spare avoids it
   always_ff @(posedge mclk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
         vacant_access_flag_out <= 1'b0;
      else
         vacant_access_flag_out <= map_vacant ||
                                   (irq_fetched && !irq_req_in);
   end

   // fetch address shows the look-ahead address
   always_ff @(posedge mclk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
         fetch_address_bus_out <= CPQ_PC_RESET;
      else if (instr_valid_in)
         fetch_address_bus_out <= check_addr;
   end

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   pc_offset_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
      instr_valid_in && pc_arith |=> pc_out == $past(instr_addr_in) + CPQ_PC_CORR +
         $past(operand_in))
      else $error("pc arithmetic base wrong");
   pc_move_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
      instr_valid_in && pcmod_in == CPQ_PM_MOVE |=> pc_out == $past(move_src_in))
      else $error("move into pc altered");
   ea_wrap_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
      instr_valid_in && far_indexed_in && base_reg_in[CPQ_AW-1:CPQ_LOW_W] == '0
      |=> ea_valid_out && ea_out[CPQ_AW-1:CPQ_LOW_W] == '0)
      else $error("far indexed address left 64k");
   double_pc_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
      st == CPQ_ST_IDLE && irq_take_in && defect_armed
      |=> push_valid_out && !push_is_sr_out ##1 push_valid_out && !push_is_sr_out)
      else $error("defect stacking not two pc words");
   push_order_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
      st == CPQ_ST_IDLE && irq_take_in && !defect_armed
      |=> push_valid_out && !push_is_sr_out ##1 push_valid_out && push_is_sr_out
      ##1 !push_valid_out)
      else $error("interrupt entry order wrong");
   nop_guard_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
      instr_valid_in && !lpm_prev && is_call_in && !defect_armed && st != CPQ_ST_PUSH2
      |=> !defect_armed)
      else $error("hazard armed without low-power entry");
   lost_irq_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
      irq_fetched && !irq_req_in |=> vacant_access_flag_out)
      else $error("withdrawn interrupt not flagged");
   edge_fetch_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
      map_check ##1 map_vacant |=> vacant_access_flag_out)
      else $error("vacant fetch not flagged");
endmodule : cpq_core
`default_nettype wire

/* File: test/cpq_irq_src.sv */
// interrupt source model facing the core's interrupt side
`timescale 1ns/1ps
`default_nettype none
module cpq_irq_src
(
   input wire logic mclk_in,
   output logic irq_req_out,
   output logic irq_take_out
);
   initial
   begin
      irq_req_out = 1'b0;
      irq_take_out = 1'b0;
   end
   // request and entry strobe together; callers keep entries 3 cycles apart
   task automatic serve();
      @(negedge mclk_in);
      irq_req_out = 1'b1;
      irq_take_out = 1'b1;
      @(negedge mclk_in);
      irq_take_out = 1'b0;
      irq_req_out = 1'b0;
   endtask : serve
   // request seen for one cycle, then dropped before any entry
   task automatic withdraw();
      @(negedge mclk_in);
      irq_req_out = 1'b1;
      @(negedge mclk_in);
      irq_req_out = 1'b0;
   endtask : withdraw
endmodule : cpq_irq_src
`default_nettype wire

/* File: test/tb.sv */
// self-checking bench for the pc and address quirk core
`timescale 1ns/1ps
`default_nettype none
module tb;
   import cpq_pkg::*;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic [CPQ_NSEC*CPQ_AW-1:0] sec_lo = {20'h10000, 20'h10000, 20'h08000, 20'h00000};
   logic [CPQ_NSEC*CPQ_AW-1:0] sec_hi = {20'h1ffff, 20'h1ffff, 20'h0ffff, 20'h00fff};
   logic iv = 1'b0, fi = 1'b0, lpm = 1'b0, call = 1'b0;
   logic [CPQ_AW-1:0] ia = '0, op = '0, ms = '0, br = '0;
   cpq_pcmod_t pm = CPQ_PM_NONE;
   cpq_am_t sm = CPQ_AM_REG;
   logic [CPQ_DW-1:0] ix = '0, sr = '0;
   logic irq_req, irq_take, ea_valid, push_valid, push_is_sr, vac;
   logic [CPQ_AW-1:0] pc, ea, push_data, fab;
   logic [20:0] pq[$];
   int vcnt = 0;
   int error_cnt = 0;
   int n_compared = 0;
   cpq_core cpq_core_i (.mclk_in(clk), .rst_n_in(rst_n), .sec_lo_in(sec_lo),
      .sec_hi_in(sec_hi), .instr_valid_in(iv), .instr_addr_in(ia), .pcmod_in(pm),
      .src_mode_in(sm), .operand_in(op), .move_src_in(ms), .far_indexed_in(fi),
      .base_reg_in(br), .index_in(ix), .sets_lpm_in(lpm), .is_call_in(call),
      .irq_req_in(irq_req), .irq_take_in(irq_take), .sr_in(sr), .pc_out(pc),
      .ea_out(ea), .ea_valid_out(ea_valid), .push_valid_out(push_valid),
      .push_data_out(push_data), .push_is_sr_out(push_is_sr),
      .vacant_access_flag_out(vac), .fetch_address_bus_out(fab));
   cpq_irq_src cpq_irq_src_i (.mclk_in(clk), .irq_req_out(irq_req),
      .irq_take_out(irq_take));
   // clock at 200 MHz
   initial
   begin
      forever #2.5 clk = ~clk;
   end
   // pulses are logged at the falling edge, where they have settled
   always @(negedge clk)
   begin
      if (push_valid === 1'b1) pq.push_back({push_is_sr, push_data});
      if (vac === 1'b1) vcnt++;
   end
   task automatic chk(input logic [20:0] got, input logic [20:0] exp);
      n_compared++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic instr(input logic [19:0] a, input cpq_pcmod_t p, input cpq_am_t m,
                        input logic l, input logic c);
      @(negedge clk);
      iv = 1'b1;
      ia = a;
      pm = p;
      sm = m;
      lpm = l;
      call = c;
   endtask : instr
   task automatic idle(input int n);
      @(negedge clk);
      iv = 1'b0;
      fi = 1'b0;
      repeat (n - 1) @(negedge clk);
   endtask : idle
   // arithmetic forms by source mode, and a move into the pc
   task automatic t_pc();
      cpq_am_t md[3] = '{CPQ_AM_IMM, CPQ_AM_IND, CPQ_AM_REG};
      logic [19:0] cr[3] = '{20'h00002, 20'h00002, 20'h00004};
      op = 20'h00100;
      ms = 20'h05000;
      for (int k = 0; k < 3; k++)
      begin
         instr(20'h01000, CPQ_PM_ARITH, md[k], 1'b0, 1'b0);
         idle(1);
         chk(pc, 20'h01100 + cr[k]);
         chk(fab, 20'h01002);
      end
      instr(20'h01000, CPQ_PM_MOVE, CPQ_AM_IMM, 1'b0, 1'b0);
      idle(1);
      chk(pc, 20'h05000);
   endtask : t_pc
   // far indexed address below and above the 64k line
   task automatic t_far();
      logic [19:0] bs[2] = '{20'h0fffe, 20'h1fffe};
      logic [19:0] ex[2] = '{20'h00002, 20'h20002};
      for (int k = 0; k < 2; k++)
      begin
         instr(20'h01000, CPQ_PM_NONE, CPQ_AM_IDX, 1'b0, 1'b1);
         fi = 1'b1;
         br = bs[k];
         ix = 16'h0004;
         idle(1);
         chk(ea_valid, 1'b1);
         chk(ea, ex[k]);
      end
   endtask : t_far
   // one entry; second word is the status or a repeated pc when armed
   task automatic irq_run(input logic twice);
      logic [19:0] p;
      pq.delete();
      sr = 16'h00a5;
      p = pc;
      cpq_irq_src_i.serve();
      repeat (4) @(negedge clk);
      chk(21'(pq.size()), 21'd2);
      chk(pq[0], {1'b0, p});
      chk(pq[1], twice ? {1'b0, p} : 21'h1000a5);
   endtask : irq_run
   task automatic t_irq();
      irq_run(1'b0);
      instr(20'h02000, CPQ_PM_NONE, CPQ_AM_REG, 1'b1, 1'b0);
      instr(20'h02002, CPQ_PM_NONE, CPQ_AM_REG, 1'b0, 1'b1);
      idle(2);
      irq_run(1'b1);
      irq_run(1'b0);
      instr(20'h02000, CPQ_PM_NONE, CPQ_AM_ABS, 1'b1, 1'b0);
      instr(20'h02002, CPQ_PM_NONE, CPQ_AM_REG, 1'b0, 1'b0);
      instr(20'h02004, CPQ_PM_NONE, CPQ_AM_REG, 1'b0, 1'b1);
      idle(2);
      irq_run(1'b0);
   endtask : t_irq
   // spurious vacant flag at a section end, or after a withdrawn request
   task automatic vac_run(input logic [19:0] a, input cpq_pcmod_t p, input int n);
      vcnt = 0;
      instr(a, p, CPQ_AM_IMM, 1'b0, 1'b0);
      idle(5);
      chk(21'(vcnt), 21'(n));
   endtask : vac_run
   task automatic t_vac();
      vac_run(20'h00ffe, CPQ_PM_ARITH, 1);
      vac_run(20'h0fffe, CPQ_PM_ARITH, 0);
      vac_run(20'h00ffe, CPQ_PM_NONE, 0);
      vac_run(20'h00ffa, CPQ_PM_ARITH, 0);
      vcnt = 0;
      cpq_irq_src_i.withdraw();
      repeat (4) @(negedge clk);
      chk(21'(vcnt), 21'd1);
   endtask : t_vac
   task automatic complete_run();
      $display("compared %0d mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : complete_run
   // watchdog well beyond the roughly 80 cycles the tests need
   initial
   begin
      #20000;
      error_cnt++;
      complete_run();
   end
   initial
   begin
      repeat (4) @(negedge clk);
      rst_n = 1'b1;
      @(negedge clk);
      chk(pc, 20'h00000);
      chk(vac, 1'b0);
      t_pc();
      t_far();
      t_irq();
      t_vac();
      complete_run();
   end
endmodule : tb
`default_nettype wire
